// >>> hdl/pocap_pkg.sv
package pocap_pkg;

  // Strap bus width and number of strap registers
  localparam int POCAP_STRAP_W = 64;
  localparam int POCAP_REG_N   = 4;

  // Register indexes; the byte address is four times the index
  localparam logic [7:0]  POCAP_IDX_PCI_MEM  = 8'h4A;
  localparam logic [7:0]  POCAP_IDX_RSVD     = 8'h4B;
  localparam logic [7:0]  POCAP_IDX_CLK_PAD  = 8'h4C;
  localparam logic [7:0]  POCAP_IDX_HOST_SPD = 8'h5F;
  localparam logic [11:0] POCAP_ADDR_PCI_MEM  = {2'h0, POCAP_IDX_PCI_MEM, 2'h0};
  localparam logic [11:0] POCAP_ADDR_RSVD     = {2'h0, POCAP_IDX_RSVD, 2'h0};
  localparam logic [11:0] POCAP_ADDR_CLK_PAD  = {2'h0, POCAP_IDX_CLK_PAD, 2'h0};
  localparam logic [11:0] POCAP_ADDR_HOST_SPD = {2'h0, POCAP_IDX_HOST_SPD, 2'h0};

  // Slot of each register inside the read array
  localparam logic [1:0] POCAP_SLOT_PCI_MEM  = 2'h0;
  localparam logic [1:0] POCAP_SLOT_RSVD     = 2'h1;
  localparam logic [1:0] POCAP_SLOT_CLK_PAD  = 2'h2;
  localparam logic [1:0] POCAP_SLOT_HOST_SPD = 2'h3;

  // Strap line numbers
  localparam int POCAP_SL_RSV_PM   = 1;
  localparam int POCAP_SL_HSPD_B6  = 2;
  localparam int POCAP_SL_HSPD_B7  = 3;
  localparam int POCAP_SL_DIV_HI   = 4;
  localparam int POCAP_SL_SYNC     = 5;
  localparam int POCAP_SL_RANGE    = 6;
  localparam int POCAP_SL_RSV_B    = 10;
  localparam int POCAP_SL_RSV_PAD  = 16;
  localparam int POCAP_SL_DIV_LO   = 17;
  localparam int POCAP_SL_HOST_PAD = 18;
  localparam int POCAP_SL_MEM_PAD  = 19;
  localparam int POCAP_SL_DOT_PAD  = 20;
  localparam int POCAP_SL_RSV_HS   = 21;
  localparam int POCAP_SL_HSPD_LO  = 24;
  localparam int POCAP_SL_CORE     = 40;

  // Field positions and widths
  localparam int POCAP_RANGE_W    = 2;
  localparam int POCAP_RSV_B_W    = 6;
  localparam int POCAP_RSV_HS_W   = 3;
  localparam int POCAP_HSPD_LO_W  = 3;
  localparam int POCAP_HSPD_W     = 5;
  localparam int POCAP_B_PM_DIV   = 4;
  localparam int POCAP_B_PM_SYNC  = 5;
  localparam int POCAP_B_PM_RANGE = 6;
  localparam int POCAP_B_RSV_LO   = 2;
  localparam int POCAP_B_PAD_DIV  = 1;
  localparam int POCAP_B_PAD_HOST = 2;
  localparam int POCAP_B_PAD_MEM  = 3;
  localparam int POCAP_B_PAD_DOT  = 4;
  localparam int POCAP_B_HS_SPD   = 3;

  // PCI output divider codes and ratios
  localparam logic [1:0] POCAP_DIV_RSVD = 2'h0;
  localparam logic [1:0] POCAP_DIV_4    = 2'h1;
  localparam logic [1:0] POCAP_DIV_3    = 2'h2;
  localparam logic [2:0] POCAP_RATIO_4  = 3'h4;
  localparam logic [2:0] POCAP_RATIO_3  = 3'h3;
  localparam logic [2:0] POCAP_RATIO_2  = 3'h2;

  // Reset values
  localparam logic        POCAP_DOT_RST   = 1'h0;
  localparam logic [31:0] POCAP_RDATA_RST = 32'h0;

  typedef enum logic {POCAP_ARMED, POCAP_HELD} pocap_cap_state_e;

endpackage

// >>> hdl/pocap_reg_if.sv
`timescale 1ns/1ps
interface pocap_reg_if import pocap_pkg::*; ();
  logic [7:0] reg_val [POCAP_REG_N];
  logic       wr_stb;
  logic [1:0] wr_slot;
  logic [7:0] wr_data;
  modport slave (input reg_val, output wr_stb, wr_slot, wr_data);
  modport regs  (output reg_val, input wr_stb, wr_slot, wr_data);
endinterface

// >>> hdl/pocap_strap_sampler.sv
`timescale 1ns/1ps
module pocap_strap_sampler import pocap_pkg::*; #(
  parameter int STRAP_W = POCAP_STRAP_W
) (
  input  wire logic               clk_sys,    // System clock
  input  wire logic               resetn,     // Async reset, low
  input  wire logic [STRAP_W-1:0] strap_line, // Strap levels
  output logic      [STRAP_W-1:0] captured,   // Held strap image
  output logic                    held,       // Image is valid
  output logic                    cap_stb     // Pulse after capture
);

  pocap_cap_state_e state;

  // Reset only loads constants; the straps are taken on the first edge
  // after release, so a strap is never copied by the async path
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state    <= POCAP_ARMED;
      captured <= '0;
      cap_stb  <= 1'b0;
    end else begin
      cap_stb <= (state == POCAP_ARMED);
      unique case (state)
        POCAP_ARMED: begin
          captured <= strap_line;
          state    <= POCAP_HELD;
        end
        POCAP_HELD: begin
          captured <= captured; // Later bus traffic is ignored
        end
      endcase
    end
  end

  assign held = (state == POCAP_HELD);

endmodule

// >>> hdl/pocap_apb_slave.sv
`timescale 1ns/1ps
module pocap_apb_slave import pocap_pkg::*; (
  input  wire logic        clk_sys, // System clock
  input  wire logic        resetn,  // Async reset, low
  input  wire logic        psel,    // APB select
  input  wire logic        penable, // APB access phase
  input  wire logic        pwrite,  // APB direction
  input  wire logic [11:0] paddr,   // APB byte address
  input  wire logic [31:0] pwdata,  // APB write data
  input  wire logic [3:0]  pstrb,   // APB byte strobes
  output logic      [31:0] prdata,  // APB read data
  output logic             pready,  // APB ready
  output logic             pslverr, // APB error
  pocap_reg_if.slave       bus      // Register array side
);

  logic [31:0] rdata_word;
  logic        err_q;
  logic        hit;
  logic [1:0]  hit_slot;
  logic        setup;
  logic        access;

  // Address decode; only the four aligned words hit, any other address answers with an error
  assign hit = (paddr == POCAP_ADDR_PCI_MEM) || (paddr == POCAP_ADDR_RSVD)
            || (paddr == POCAP_ADDR_CLK_PAD) || (paddr == POCAP_ADDR_HOST_SPD);
  assign hit_slot = (paddr == POCAP_ADDR_RSVD)     ? POCAP_SLOT_RSVD :
                    (paddr == POCAP_ADDR_CLK_PAD)  ? POCAP_SLOT_CLK_PAD :
                    (paddr == POCAP_ADDR_HOST_SPD) ? POCAP_SLOT_HOST_SPD :
                                                     POCAP_SLOT_PCI_MEM;
  assign setup  = psel && !penable;
  assign access = psel && penable;

  // Read data is latched in setup so the access phase needs no wait
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata_word <= POCAP_RDATA_RST;
      err_q      <= 1'b0;
    end else if (setup) begin
      rdata_word <= (hit && !pwrite) ? {24'h0, bus.reg_val[hit_slot]}
                                     : POCAP_RDATA_RST;
      err_q      <= !hit;
    end
  end
  // Strobes to the register array; a write lands at the ready edge
  assign prdata      = rdata_word;
  assign pready      = access;
  assign pslverr     = access && err_q;
  assign bus.wr_stb  = access && pwrite && hit && pstrb[0];
  assign bus.wr_slot = hit_slot;
  assign bus.wr_data = pwdata[7:0];

endmodule

// >>> hdl/pocap_top.sv
// Summary of operation
// - Strap line 5 goes to pci_and_memory_clock_straps bit 5; 1 means synchronised clocks.
// - Strap line 18 goes to clock_pad_direction_straps bit 2; 1 drives host clock pad.
// - Strap line 19 goes to clock_pad_direction_straps bit 3; 1 drives memory clock pad.
// - Strap line 20 goes to clock_pad_direction_straps bit 4; 1 drives dot clock pad.
// - Strap line 40 sets core rate in hardware only; 1 is double rate.
// - Strap line 4 goes to pci_and_memory_clock_straps bit 4, upper divider bit.
// - Strap lines 7 and 6 form the PCI clock range in 4A bits 7:6.
// - Host_clock_speed_straps bits 7:3 hold lines 3, 2, 26, 25, 24 as speed code.
// - Strap line 17 goes to clock_pad_direction_straps bit 1, lower divider bit.
// - Reserved lines 10-15, 16 and 21-23 fill their reserved bits.
// - Strap registers hold the sampled levels after reset.
// - Only the dot clock bit is writable; other bits are read-only.
// - PCI clock is system clock over 4, 3, 2 for codes 01, 10, 11.
`timescale 1ns/1ps
module pocap_top import pocap_pkg::*; #(
  parameter int STRAP_W = POCAP_STRAP_W
) (
  input  wire logic               clk_sys,               // 40 MHz clock
  input  wire logic               resetn,                // Async reset
  input  wire logic               psel,                  // APB select
  input  wire logic               penable,               // APB enable
  input  wire logic               pwrite,                // APB write
  input  wire logic [11:0]        paddr,                 // APB address
  input  wire logic [31:0]        pwdata,                // APB wdata
  input  wire logic [3:0]         pstrb,                 // APB strobes
  input  wire logic [STRAP_W-1:0] strap_line,            // Strap levels
  output logic      [31:0]        prdata,                // APB rdata
  output logic                    pready,                // APB ready
  output logic                    pslverr,               // APB error
  output logic                    straps_valid,          // Image held
  output logic                    clocks_synchronised,   // Mem/host sync
  output logic      [1:0]         pci_clock_range,       // PCI range
  output logic      [4:0]         host_clock_speed_code, // Host speed
  output logic                    host_clock_pad_drive_en, // Host pad out
  output logic                    memory_clock_pad_drive_en, // Mem pad
  output logic                    dot_clock_pad_drive_en,  // Dot pad out
  output logic                    double_rate_core,      // Core x2
  output logic                    single_rate_core,      // Core x1
  output logic                    pci_clock_out_pin,     // Divided clock
  output logic                    pci_clock_divided_out, // Divider pulse
  output logic                    pci_divider_reserved   // Code 00 seen
);

  logic [STRAP_W-1:0] cap;
  logic               cap_stb;
  logic               dot_src;
  logic [7:0]         reg_pci_mem;
  logic [7:0]         reg_rsvd;
  logic [7:0]         reg_clk_pad;
  logic [7:0]         reg_host_spd;
  logic [1:0]         div_code;
  logic [2:0]         div_ratio;
  logic [2:0]         div_last;
  logic [2:0]         div_half;
  logic               div_run;
  logic [2:0]         div_cnt;
  logic [2:0]         next_div_cnt;
  logic               pin_q;
  logic               pulse_q;
  logic               pad_wr;

  pocap_reg_if reg_bus ();

  // Sampler holds the strap image from the first edge after reset
  pocap_strap_sampler #(
    .STRAP_W    (STRAP_W)
  ) u_sampler (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .strap_line (strap_line),
    .captured   (cap),
    .held       (straps_valid),
    .cap_stb    (cap_stb)
  );

  // Bus front end answers with zero wait states
  pocap_apb_slave u_apb (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pstrb   (pstrb),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .bus     (reg_bus.slave)
  );

  // Strap register images; unassigned bits are tied low
  assign reg_pci_mem = {cap[POCAP_SL_RANGE+1],
                        cap[POCAP_SL_RANGE],
                        cap[POCAP_SL_SYNC],
                        cap[POCAP_SL_DIV_HI],
                        cap[POCAP_SL_HSPD_B7],
                        cap[POCAP_SL_HSPD_B6],
                        cap[POCAP_SL_RSV_PM],
                        1'b0};
  assign reg_rsvd    = {cap[POCAP_SL_RSV_B +: POCAP_RSV_B_W],
                        2'b00};
  assign reg_clk_pad = {3'b000,
                        dot_src,
                        cap[POCAP_SL_MEM_PAD],
                        cap[POCAP_SL_HOST_PAD],
                        cap[POCAP_SL_DIV_LO],
                        cap[POCAP_SL_RSV_PAD]};
  assign reg_host_spd = {cap[POCAP_SL_HSPD_B7],
                         cap[POCAP_SL_HSPD_B6],
                         cap[POCAP_SL_HSPD_LO +: POCAP_HSPD_LO_W],
                         cap[POCAP_SL_RSV_HS +: POCAP_RSV_HS_W]};

  // Read array seen by the bus front end
  assign reg_bus.reg_val[POCAP_SLOT_PCI_MEM]  = reg_pci_mem;
  assign reg_bus.reg_val[POCAP_SLOT_RSVD]     = reg_rsvd;
  assign reg_bus.reg_val[POCAP_SLOT_CLK_PAD]  = reg_clk_pad;
  assign reg_bus.reg_val[POCAP_SLOT_HOST_SPD] = reg_host_spd;

  // Writes to any other register or bit are accepted and dropped
  assign pad_wr = reg_bus.wr_stb && (reg_bus.wr_slot == POCAP_SLOT_CLK_PAD);

  // Dot clock source: strap value first, software may override later.
  // The capture pulse wins so a stray early write cannot hide the strap.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dot_src <= POCAP_DOT_RST;
    end else if (cap_stb) begin
      dot_src <= cap[POCAP_SL_DOT_PAD];
    end else if (pad_wr) begin
      dot_src <= reg_bus.wr_data[POCAP_B_PAD_DOT];
    end
  end

  // Decoded configuration outputs, straight from flops except single_rate_core, gated by straps_valid
  assign clocks_synchronised       = reg_pci_mem[POCAP_B_PM_SYNC];
  assign pci_clock_range           = reg_pci_mem[POCAP_B_PM_RANGE +:
                                                 POCAP_RANGE_W];
  assign host_clock_speed_code     = reg_host_spd[POCAP_B_HS_SPD +:
                                                  POCAP_HSPD_W];
  assign host_clock_pad_drive_en   = reg_clk_pad[POCAP_B_PAD_HOST];
  assign memory_clock_pad_drive_en = reg_clk_pad[POCAP_B_PAD_MEM];
  assign dot_clock_pad_drive_en    = reg_clk_pad[POCAP_B_PAD_DOT];
  assign double_rate_core          = cap[POCAP_SL_CORE];
  assign single_rate_core          = straps_valid && !cap[POCAP_SL_CORE];

  // Divider code: strap line 4 is the upper bit, line 17 the lower
  assign div_code = {reg_pci_mem[POCAP_B_PM_DIV],
                     reg_clk_pad[POCAP_B_PAD_DIV]};
  assign div_ratio = (div_code == POCAP_DIV_4) ? POCAP_RATIO_4 :
                     (div_code == POCAP_DIV_3) ? POCAP_RATIO_3 :
                                                 POCAP_RATIO_2;
  assign div_last  = div_ratio - 3'h1;
  assign div_half  = div_ratio >> 1;
  assign div_run   = straps_valid && (div_code != POCAP_DIV_RSVD);
  assign next_div_cnt = (div_cnt == div_last) ? 3'h0 : div_cnt + 3'h1;
  assign pci_divider_reserved = straps_valid &&
                                (div_code == POCAP_DIV_RSVD);

  // PCI clock divider off the system clock; the reserved code parks it
  // low rather than guess a ratio. Odd ratio gives a short high phase.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      div_cnt <= 3'h0;
      pin_q   <= 1'b0;
      pulse_q <= 1'b0;
    end else if (div_run) begin
      div_cnt <= next_div_cnt;
      pin_q   <= (next_div_cnt < div_half);
      pulse_q <= (div_cnt == div_last);
    end else begin
      div_cnt <= 3'h0;
      pin_q   <= 1'b0;
      pulse_q <= 1'b0;
    end
  end

  assign pci_clock_out_pin     = pin_q;
  assign pci_clock_divided_out = pulse_q;

  // Checks on the captured image and the derived outputs
  property p_sync_bit;
    @(posedge clk_sys) disable iff (!resetn)
    $rose(straps_valid) |-> clocks_synchronised == $past(strap_line[5]);
  endproperty
  a_sync_bit: assert property (p_sync_bit)
    else $error("sync bit differs from sampled strap");

  property p_host_pad;
    @(posedge clk_sys) disable iff (!resetn)
    straps_valid |-> host_clock_pad_drive_en == cap[18]
                     && reg_clk_pad[2] == cap[18];
  endproperty
  a_host_pad: assert property (p_host_pad)
    else $error("host pad direction wrong");

  property p_mem_pad;
    @(posedge clk_sys) disable iff (!resetn)
    straps_valid |-> memory_clock_pad_drive_en == cap[19]
                     && reg_clk_pad[3] == cap[19];
  endproperty
  a_mem_pad: assert property (p_mem_pad)
    else $error("memory pad direction wrong");

  property p_dot_load;
    @(posedge clk_sys) disable iff (!resetn)
    $rose(straps_valid) |=> dot_clock_pad_drive_en == cap[20]
                            && reg_clk_pad[4] == cap[20];
  endproperty
  a_dot_load: assert property (p_dot_load)
    else $error("dot pad not loaded from strap");

  property p_core_rate;
    @(posedge clk_sys) disable iff (!resetn)
    $rose(straps_valid) |-> double_rate_core == $past(strap_line[40])
                            && single_rate_core != double_rate_core;
  endproperty
  a_core_rate: assert property (p_core_rate)
    else $error("core rate select wrong");

  property p_div_code;
    @(posedge clk_sys) disable iff (!resetn)
    straps_valid |-> div_code == {cap[4], cap[17]}
                     && reg_pci_mem[4] == cap[4]
                     && reg_clk_pad[1] == cap[17];
  endproperty
  a_div_code: assert property (p_div_code)
    else $error("divider code not from lines 4 and 17");

  property p_range;
    @(posedge clk_sys) disable iff (!resetn)
    straps_valid |-> pci_clock_range == {cap[7], cap[6]};
  endproperty
  a_range: assert property (p_range)
    else $error("PCI range field wrong");

  property p_speed;
    @(posedge clk_sys) disable iff (!resetn)
    straps_valid |-> host_clock_speed_code ==
                     {cap[3], cap[2], cap[26], cap[25], cap[24]};
  endproperty
  a_speed: assert property (p_speed)
    else $error("host speed code wrong");

  property p_reserved_lines;
    @(posedge clk_sys) disable iff (!resetn)
    straps_valid |-> reg_rsvd[7:2] == cap[15:10] && reg_clk_pad[0] == cap[16]
                     && reg_host_spd[2:0] == cap[23:21];
  endproperty
  a_reserved_lines: assert property (p_reserved_lines)
    else $error("reserved strap bits misplaced");

  property p_hold;
    @(posedge clk_sys) disable iff (!resetn)
    straps_valid |=> straps_valid && $stable(cap);
  endproperty
  a_hold: assert property (p_hold)
    else $error("strap image changed after capture");

  property p_ro_bits;
    @(posedge clk_sys) disable iff (!resetn)
    straps_valid && pad_wr |=> reg_clk_pad[3:0] == $past(reg_clk_pad[3:0])
                     && reg_pci_mem == $past(reg_pci_mem);
  endproperty
  a_ro_bits: assert property (p_ro_bits)
    else $error("read-only strap bit changed by write");

  property p_dot_write;
    @(posedge clk_sys) disable iff (!resetn)
    pad_wr && !cap_stb |=> dot_clock_pad_drive_en == $past(pwdata[4]);
  endproperty
  a_dot_write: assert property (p_dot_write)
    else $error("dot bit write not taken");

  property p_zero_bits;
    @(posedge clk_sys) disable iff (!resetn)
    reg_pci_mem[0] == 1'b0 && reg_rsvd[1:0] == 2'b00
    && reg_clk_pad[7:5] == 3'b000;
  endproperty
  a_zero_bits: assert property (p_zero_bits)
    else $error("unassigned bit reads one");

  property p_div4;
    @(posedge clk_sys) disable iff (!resetn)
    pulse_q && div_code == 2'b01 |=> !pulse_q [*3] ##1 pulse_q;
  endproperty
  a_div4: assert property (p_div4)
    else $error("divide by 4 period wrong");

  property p_div3;
    @(posedge clk_sys) disable iff (!resetn)
    pulse_q && div_code == 2'b10 |=> !pulse_q [*2] ##1 pulse_q;
  endproperty
  a_div3: assert property (p_div3)
    else $error("divide by 3 period wrong");

  property p_div2;
    @(posedge clk_sys) disable iff (!resetn)
    pulse_q && div_code == 2'b11 |=> !pulse_q ##1 pulse_q;
  endproperty
  a_div2: assert property (p_div2)
    else $error("divide by 2 period wrong");

  property p_div_rsvd;
    @(posedge clk_sys) disable iff (!resetn)
    straps_valid && div_code == 2'b00 |=> !pulse_q && !pci_clock_out_pin;
  endproperty
  a_div_rsvd: assert property (p_div_rsvd)
    else $error("reserved divider code produced a clock");

endmodule

// >>> tb/pocap_strap_board.sv
`timescale 1ns/1ps
// Resistors on the memory data lines; once bus_on is set the memory
// bus owns the lines and they no longer show the strap levels
module pocap_strap_board import pocap_pkg::*; (
  input  wire logic [POCAP_STRAP_W-1:0] pattern,    // Fitted resistors
  input  wire logic                     clk_sys,    // System clock
  input  wire logic                     bus_on,     // Memory traffic
  output logic      [POCAP_STRAP_W-1:0] strap_line  // Line levels
);
  logic [POCAP_STRAP_W-1:0] traffic; // Rotates one bit each cycle while bus_on is set
  // Inverse of the straps, rotated, so a sample in the first bus_on cycle is wrong in every bit
  always_ff @(posedge clk_sys) begin
    if (!bus_on) begin
      traffic <= ~pattern;
    end else begin
      traffic <= {traffic[0], traffic[POCAP_STRAP_W-1:1]};
    end
  end
  assign strap_line = bus_on ? traffic : pattern;
endmodule

// >>> tb/power_on_strap_capture_tb.sv
`timescale 1ns/1ps
module power_on_strap_capture_tb import pocap_pkg::*;;
  typedef struct packed {logic [63:0] pat; logic [31:0] per;} pocap_row_s;
  logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, bus_on;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, gp, hi;
  logic [3:0] pstrb;
  logic [63:0] pattern, strap_line;
  logic sv, cs, hp, mp, dp, dr, sr, po, pd, pr, er;
  logic [1:0] rng;
  logic [4:0] spd;
  int errors = 0;
  int tests_run = 0;
  // Strap images beside the divider period each should give
  pocap_row_s rows [4] = '{'{64'hFFFFFFFFFFFFFFFF, 32'h2},
    '{64'h0, 32'h0}, '{64'hAAAAAAAAAAAAAAAA, 32'h4},
    '{64'h5555555555555555, 32'h3}};
  logic [11:0] addrs [4] = '{POCAP_ADDR_PCI_MEM, POCAP_ADDR_RSVD,
    POCAP_ADDR_CLK_PAD, POCAP_ADDR_HOST_SPD};

  pocap_strap_board board (.pattern(pattern), .clk_sys(clk_sys),
    .bus_on(bus_on), .strap_line(strap_line));
  pocap_top #(.STRAP_W(POCAP_STRAP_W)) dut (.clk_sys(clk_sys),
    .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .strap_line(strap_line), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .straps_valid(sv), .clocks_synchronised(cs),
    .pci_clock_range(rng), .host_clock_speed_code(spd),
    .host_clock_pad_drive_en(hp), .memory_clock_pad_drive_en(mp),
    .dot_clock_pad_drive_en(dp), .double_rate_core(dr),
    .single_rate_core(sr), .pci_clock_out_pin(po),
    .pci_clock_divided_out(pd), .pci_divider_reserved(pr));

  initial begin
    clk_sys = 1'h0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic end_sim();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Register contents worked out from the strap map
  function automatic logic [31:0] exp_reg(input logic [63:0] s,
                                          input int k);
    case (k)
      0: exp_reg = {24'h0, s[7:1], 1'h0};
      1: exp_reg = {24'h0, s[15:10], 2'h0};
      2: exp_reg = {27'h0, s[20:16]};
      default: exp_reg = {24'h0, s[3:2], s[26:21]};
    endcase
  endfunction

  // One APB transfer; the idle edge first keeps drivers single-valued
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s, output logic e);
    int c;
    @(posedge clk_sys);
    psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'h1;
    for (c = 0; c < 16; c++) begin
      @(posedge clk_sys);
      if (pready === 1'h1) break;
    end
    if (c == 16) begin
      errors++;
      end_sim();
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic start(input logic [63:0] p);
    @(posedge clk_sys);
    resetn <= 1'h0; bus_on <= 1'h0; pattern <= p;
    repeat (3) @(posedge clk_sys);
    chk({31'h0, sv}, 32'h0);
    resetn <= 1'h1;
    repeat (2) @(posedge clk_sys);
    chk({31'h0, sv}, 32'h1);
  endtask

  task automatic read_all(input logic [63:0] p);
    for (int k = 0; k < 4; k++) begin
      apb(1'h0, addrs[k], 32'h0, 4'hF, er);
      chk(rd, exp_reg(p, k));
      chk({31'h0, er}, 32'h0);
    end
  endtask

  // Cycles between two divider pulses, zero when none come
  task automatic gap(output logic [31:0] n);
    int t0;
    t0 = -1;
    n = 32'h0;
    for (int c = 0; c < 20 && n == 0; c++) begin
      @(negedge clk_sys);
      if (pd === 1'h1 && t0 >= 0) n = c - t0;
      if (pd === 1'h1 && t0 < 0) t0 = c;
    end
  endtask

  initial begin
    resetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
    paddr = 12'h0; pwdata = 32'h0; pstrb = 4'hF; pattern = 64'h0;
    bus_on = 1'h0;
    for (int r = 0; r < 4; r++) begin
      start(rows[r].pat);
      read_all(rows[r].pat);
      @(negedge clk_sys);
      chk({18'h0, cs, rng, spd, hp, mp, dp, dr, sr, pr},
        {18'h0, rows[r].pat[5], rows[r].pat[7:6], rows[r].pat[3:2],
         rows[r].pat[26:24], rows[r].pat[18], rows[r].pat[19],
         rows[r].pat[20], rows[r].pat[40], ~rows[r].pat[40],
         rows[r].per == 32'h0});
      gap(gp);
      chk(gp, rows[r].per);
      // High cycles of the divided clock over a window of whole periods
      hi = 32'h0;
      repeat (12) begin
        @(negedge clk_sys);
        hi = hi + {31'h0, po};
      end
      gp = (rows[r].per == 32'h0) ? 32'h0
         : 32'hC / rows[r].per * (rows[r].per >> 1);
      chk(hi, gp);
    end
    // Memory traffic after capture must not reach the image
    bus_on <= 1'h1;
    repeat (6) @(posedge clk_sys);
    read_all(rows[3].pat);
    chk({27'h0, spd}, {27'h0, rows[3].pat[3:2], rows[3].pat[26:24]});
    // Dot source bit is writable; other bits and lanes are not
    apb(1'h1, POCAP_ADDR_CLK_PAD, 32'h0, 4'hF, er);
    chk({31'h0, er}, 32'h0);
    apb(1'h1, POCAP_ADDR_CLK_PAD, 32'hFF, 4'h0, er);
    apb(1'h1, POCAP_ADDR_PCI_MEM, 32'h0, 4'hF, er);
    apb(1'h0, POCAP_ADDR_CLK_PAD, 32'h0, 4'hF, er);
    chk(rd, exp_reg(rows[3].pat, 2) & 32'hEF);
    @(negedge clk_sys);
    chk({31'h0, dp}, 32'h0);
    apb(1'h0, POCAP_ADDR_PCI_MEM, 32'h0, 4'hF, er);
    chk(rd, exp_reg(rows[3].pat, 0));
    // Hole in the map answers with an error and no data
    apb(1'h0, 12'h134, 32'h0, 4'hF, er);
    chk({er, rd[30:0]}, 32'h80000000);
    // A second reset restores the strapped dot source
    start(rows[3].pat);
    apb(1'h0, POCAP_ADDR_CLK_PAD, 32'h0, 4'hF, er);
    chk(rd, exp_reg(rows[3].pat, 2));
    end_sim();
  end
endmodule
